// [core/gtc_regs.vh]
/*
 * constants for the i2c target command port: bus address, command space
 * limits and stuck-bus timing. assumes a 100 MHz device clock.
 */
`ifndef GTC_REGS_VH
`define GTC_REGS_VH
// 7-bit target identifier
`define GTC_TARGET_ADDR 7'h55
// highest valid command location
`define GTC_LAST_LOC 8'h7F
// command space depth and pointer width
`define GTC_MEM_DEPTH 128
`define GTC_PTR_W 7
// stuck-bus timeout default in cycles of mclk
`define GTC_STUCK_CYCLES 32'd2000000
// pointer value after reset
`define GTC_PTR_RESET 7'h00
`endif

// [core/gtc_mem.v]
/*
 * command space memory: 128 bytes, one write port, registered read.
 * assumes a single clock; read data appears one cycle after the address.
 */
`timescale 1ns/100ps
module gtc_mem
(
    input wire mclk,
    input wire we,
    input wire [6:0] waddr,
    input wire [7:0] wdata,
    input wire [6:0] raddr,
    output reg [7:0] rdata
);
    // storage array
    reg [7:0] mem [0:127];

    // write and registered read
    always @(posedge mclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // gtc_mem

// [core/gtc_target.v]
/*
 * i2c target engine with a 128-location command space, auto-advancing
 * pointer, write refusal and stuck-bus release.
 * assumes scl/sda inputs already synchronous to mclk and a host master.
 */
// Operation
// - answer only address 1010101, 0xAA/0xAB
// - byte write, quick, byte and incremental read
// - quick read returns pointer location
// - pointer advances on every acknowledged data byte
// - incremental reads use the same advancing pointer
// - nack data written to read-only location
// - nack command byte above 0x7F
// - accept first write byte, nack the rest
// - stuck bus low releases sda and scl
// - after release leave lines free
// - line still low after release: sleep
`timescale 1ns/100ps
`include "gtc_regs.vh"
module gtc_target
#(
    parameter STUCK_CYCLES = `GTC_STUCK_CYCLES
)
(
    input wire mclk,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_in,
    output reg scl_out,
    output reg scl_oe,
    output reg sda_out,
    output reg sda_oe,
    input wire [127:0] loc_writable,
    output reg [7:0] wr_data,
    output reg [6:0] wr_loc,
    output reg wr_stb,
    output reg sleep_mode
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_RECV = 6'h02;
    localparam [5:0] ST_ACK = 6'h04;
    localparam [5:0] ST_SEND = 6'h08;
    localparam [5:0] ST_MACK = 6'h10;
    localparam [5:0] ST_HALT = 6'h20;

    // byte kinds while receiving
    localparam [1:0] BY_ADDR = 2'h0;
    localparam [1:0] BY_CMD = 2'h1;
    localparam [1:0] BY_DATA = 2'h2;

    reg [5:0] state_reg;
    reg [1:0] kind_reg; // which byte is being received
    reg [2:0] bit_reg; // bit counter
    reg [7:0] sh_reg; // shift register
    reg [6:0] ptr_reg; // internal address pointer
    reg valid_reg; // pointer still inside command space
    reg wcnt_reg; // one write byte already taken
    reg nack_reg; // current ack slot answers not-acknowledge
    reg full_reg; // eight bits shifted in, byte complete
    reg scl_d_reg; // previous scl sample
    reg sda_d_reg; // previous sda sample
    reg [31:0] low_cnt_reg; // stuck-bus counter
    reg released_reg; // lines released after timeout
    wire [7:0] rd_byte; // memory read data

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // pointer plus one, carry in bit 7
    function [7:0] ptr_step;
        input [6:0] p;
        begin
            ptr_step = {1'b0, p} + 8'h01;
        end
    endfunction

    wire scl_rise = scl_in & ~scl_d_reg;
    wire scl_fall = ~scl_in & scl_d_reg;
    wire start_c = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
    wire stop_c = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
    wire bus_low = ~scl_in & ~sda_in; // both lines held low
    wire [7:0] ptr_inc = ptr_step(ptr_reg); // next pointer, carry in bit 7

    gtc_mem u_mem
    (
        .mclk(mclk),
        .we(wr_stb),
        .waddr(wr_loc),
        .wdata(wr_data),
        .raddr(ptr_reg),
        .rdata(rd_byte)
    );

    // ------------------------------------------------------------
    // stuck-bus watchdog
    // ------------------------------------------------------------
    // counter restarts whenever either line is high
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            low_cnt_reg <= 32'h0;
            released_reg <= 1'b0;
            sleep_mode <= 1'b0;
        end
        else if (!bus_low)
        begin
            low_cnt_reg <= 32'h0;
            released_reg <= 1'b0;
            sleep_mode <= 1'b0;
        end
        else if (low_cnt_reg >= STUCK_CYCLES)
        begin
            // first cycle after timeout releases; still low means external
            released_reg <= 1'b1;
            sleep_mode <= released_reg;
        end
        else
        begin
            low_cnt_reg <= low_cnt_reg + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            kind_reg <= BY_ADDR;
            bit_reg <= 3'h0;
            sh_reg <= 8'h00;
            ptr_reg <= `GTC_PTR_RESET;
            full_reg <= 1'b0;
            valid_reg <= 1'b1;
            wcnt_reg <= 1'b0;
            nack_reg <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            wr_data <= 8'h00;
            wr_loc <= 7'h00;
            wr_stb <= 1'b0;
        end
        else
        begin
            scl_d_reg <= scl_in;
            sda_d_reg <= sda_in;
            wr_stb <= 1'b0;
            scl_oe <= 1'b0; // no clock stretching
            if (released_reg)
            begin
                // drop every drive and wait for a fresh start
                sda_oe <= 1'b0;
                state_reg <= ST_HALT;
            end
            else if (start_c)
            begin
                state_reg <= ST_RECV;
                kind_reg <= BY_ADDR;
                full_reg <= 1'b0; // the start's own scl fall is no byte
                bit_reg <= 3'h0;
                sda_oe <= 1'b0;
            end
            else if (stop_c)
            begin
                state_reg <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    ST_RECV:
                    begin
                        if (scl_rise)
                        begin
                            sh_reg <= {sh_reg[6:0], sda_in};
                            bit_reg <= bit_reg + 3'h1;
                            full_reg <= (bit_reg == 3'h7);
                        end
                        else if (scl_fall && full_reg)
                        begin
                            // full byte in: decide answer
                            state_reg <= ST_ACK;
                            nack_reg <= 1'b0;
                            full_reg <= 1'b0;
                            if (kind_reg == BY_ADDR)
                            begin
                                if (sh_reg[7:1] != `GTC_TARGET_ADDR)
                                    state_reg <= ST_IDLE;
                                else
                                    sda_oe <= 1'b1;
                                wcnt_reg <= 1'b0;
                            end
                            else if (kind_reg == BY_CMD)
                            begin
                                if (sh_reg > `GTC_LAST_LOC)
                                begin
                                    nack_reg <= 1'b1;
                                    valid_reg <= 1'b0;
                                end
                                else
                                begin
                                    sda_oe <= 1'b1;
                                    ptr_reg <= sh_reg[6:0];
                                    valid_reg <= 1'b1;
                                end
                            end
                            else if (wcnt_reg || !valid_reg)
                                nack_reg <= 1'b1;
                            else if (!loc_writable[ptr_reg])
                                nack_reg <= 1'b1;
                            else
                            begin
                                // accept single byte, advance pointer
                                sda_oe <= 1'b1;
                                wr_data <= sh_reg;
                                wr_loc <= ptr_reg;
                                wr_stb <= 1'b1;
                                wcnt_reg <= 1'b1;
                                {valid_reg, ptr_reg} <=
                                    {~ptr_inc[7], ptr_inc[6:0]};
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        sda_out <= 1'b0;
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b0;
                            bit_reg <= 3'h0;
                            if (kind_reg == BY_ADDR && sh_reg[0])
                            begin
                                // read: quick read from pointer
                                state_reg <= ST_SEND;
                                sh_reg <= valid_reg ? rd_byte : 8'hFF;
                                sda_oe <= valid_reg & ~rd_byte[7];
                            end
                            else
                            begin
                                state_reg <= nack_reg ? ST_HALT : ST_RECV;
                                kind_reg <= (kind_reg == BY_ADDR) ?
                                    BY_CMD : BY_DATA;
                            end
                        end
                    end
                    ST_SEND:
                    begin
                        if (scl_fall)
                        begin
                            bit_reg <= bit_reg + 3'h1;
                            sh_reg <= {sh_reg[6:0], 1'b1};
                            if (bit_reg == 3'h7)
                            begin
                                state_reg <= ST_MACK;
                                sda_oe <= 1'b0;
                            end
                            else
                                sda_oe <= ~sh_reg[6];
                        end
                    end
                    ST_MACK:
                    begin
                        if (scl_rise)
                        begin
                            if (sda_in)
                                state_reg <= ST_HALT; // master nack
                            else
                                {valid_reg, ptr_reg} <= {valid_reg &
                                    ~ptr_inc[7], ptr_inc[6:0]};
                        end
                        else if (scl_fall)
                        begin
                            // master acked: next byte of incremental read
                            state_reg <= ST_SEND;
                            bit_reg <= 3'h0;
                            sh_reg <= valid_reg ? rd_byte : 8'hFF;
                            sda_oe <= valid_reg & ~rd_byte[7];
                        end
                    end
                    default:
                    begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // gtc_target

// [sim/gtc_target_chk.sv]
/* checker for gtc_target: bus, write strobe and stuck-bus relations.
   assumes scl_in/sda_in carry the resolved bus levels. */
`timescale 1ns/100ps
module gtc_target_chk
#(
    parameter STUCK_CYCLES = 50
)
(
    input wire mclk,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_in,
    input wire scl_out,
    input wire scl_oe,
    input wire sda_out,
    input wire sda_oe,
    input wire [127:0] loc_writable,
    input wire [7:0] wr_data,
    input wire [6:0] wr_loc,
    input wire wr_stb,
    input wire sleep_mode
);
    // ----------------
    // both-low counter
    // ----------------
    reg [31:0] low_cnt_reg; // cycles with both lines low
    // restarts as soon as either line is high
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            low_cnt_reg <= 32'h0;
        else if (!scl_in && !sda_in)
            low_cnt_reg <= low_cnt_reg + 32'h1;
        else
            low_cnt_reg <= 32'h0;
    end
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    scl_undriven_a: assert property (!scl_oe)
        else $error("scl driven");
    sda_low_a: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    ack_rise_a: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("sda taken while scl high");
    sda_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    stuck_free_a: assert property (low_cnt_reg > STUCK_CYCLES + 2 |-> !sda_oe)
        else $error("sda held past timeout");
    sleep_cause_a: assert property
        ($rose(sleep_mode) |-> low_cnt_reg >= STUCK_CYCLES - 2)
        else $error("sleep before timeout");
    sleep_quiet_a: assert property (sleep_mode |-> !sda_oe)
        else $error("sda driven in sleep");
    wr_pulse_a: assert property (wr_stb |=> !wr_stb)
        else $error("write strobe too long");
    wr_ro_a: assert property (wr_stb |-> loc_writable[wr_loc])
        else $error("read-only location written");
endmodule // gtc_target_chk

bind gtc_target gtc_target_chk #(.STUCK_CYCLES(STUCK_CYCLES)) i_gtc_target_chk
(
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .loc_writable(loc_writable), .wr_data(wr_data), .wr_loc(wr_loc),
    .wr_stb(wr_stb), .sleep_mode(sleep_mode)
);

// [sim/gtc_host.sv]
/* host bus master model: open-drain pulls on scl and sda.
   assumes pull-ups on the wires; moves lines only at falling mclk. */
`timescale 1ns/100ps
module gtc_host
(
    input wire mclk,
    input wire sda,
    output reg scl_lo,
    output reg sda_lo
);
    // lines released, clock still outside frames
    initial
    begin
        scl_lo = 1'b0;
        sda_lo = 1'b0;
    end
    // quarter bit time
    task tick;
        repeat (4) @(negedge mclk);
    endtask
    // start or repeated start
    task start;
    begin
        sda_lo = 1'b0;
        tick;
        scl_lo = 1'b0;
        tick;
        sda_lo = 1'b1;
        tick;
        scl_lo = 1'b1;
        tick;
    end
    endtask
    // one bit: set while scl low, sampled while high
    task bitx(input b, output r);
    begin
        sda_lo = !b;
        tick;
        scl_lo = 1'b0;
        tick;
        r = sda;
        tick;
        scl_lo = 1'b1;
        tick;
    end
    endtask
    // byte out msb first, ack bit back
    task wbyte(input [7:0] d, output ack);
        integer i;
        reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    end
    endtask
    // byte in, then master ack or nack
    task rbyte(input mack, output [7:0] d);
        integer i;
        reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bitx(1'b1, d[i]);
        bitx(!mack, r);
    end
    endtask
    // stop ends a transfer
    task stop;
    begin
        sda_lo = 1'b1;
        tick;
        scl_lo = 1'b0;
        tick;
        sda_lo = 1'b0;
        tick;
    end
    endtask
    // pull both lines low for n cycles
    task lowboth(input integer n);
    begin
        sda_lo = 1'b1;
        tick;
        scl_lo = 1'b1;
        repeat (n) @(negedge mclk);
    end
    endtask
endmodule // gtc_host

// [sim/gtc_target_tb.sv]
/* testbench for gtc_target: host model transfers, write queue check.
   assumes a short stuck-bus count of 50 cycles. */
`timescale 1ns/100ps
module gtc_target_tb;
    reg mclk;
    reg sys_rst;
    reg [127:0] loc_writable;
    wire scl_out, scl_oe, sda_out, sda_oe, wr_stb, sleep_mode, scl_lo, sda_lo;
    wire [7:0] wr_data;
    wire [6:0] wr_loc;
    wire scl = !(scl_lo || (scl_oe && !scl_out)); // pulled up
    wire sda = !(sda_lo || (sda_oe && !sda_out));
    integer n_mismatch = 0;
    integer num_checks = 0;
    integer i;
    reg [14:0] exp_q[$]; // expected {loc, data} writes
    reg [6:0] a;
    reg [7:0] d0, d1, d2, d4, rd;
    reg ack;
    gtc_target #(.STUCK_CYCLES(50)) i_gtc_target
    (
        .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
        .sda_oe(sda_oe), .loc_writable(loc_writable), .wr_data(wr_data),
        .wr_loc(wr_loc), .wr_stb(wr_stb), .sleep_mode(sleep_mode)
    );
    gtc_host i_gtc_host
    (
        .mclk(mclk), .sda(sda), .scl_lo(scl_lo), .sda_lo(sda_lo)
    );
    always #5 mclk = ~mclk;
    // compare and count
    task chk(input [14:0] got, input [14:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task chk_bit(input got, input exp);
        chk({14'h0, got}, {14'h0, exp});
    endtask
    task chk_byte(input [7:0] got, input [7:0] exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask
    // write strobes against oldest note
    always @(negedge mclk)
    begin
        if (wr_stb === 1'b1)
            chk({wr_loc, wr_data}, exp_q.size() ? exp_q.pop_front()
                : ~{wr_loc, wr_data});
    end
    // address for write, then command byte
    task open_cmd(input [7:0] cmd, input exp);
    begin
        i_gtc_host.start;
        i_gtc_host.wbyte(8'hAA, ack);
        chk_bit(ack, 1'b1);
        i_gtc_host.wbyte(cmd, ack);
        chk_bit(ack, exp);
    end
    endtask
    task wr(input [6:0] loc, input [7:0] d, input exp);
    begin
        open_cmd({1'b0, loc}, 1'b1);
        if (exp)
            exp_q.push_back({loc, d});
        i_gtc_host.wbyte(d, ack);
        chk_bit(ack, exp);
        i_gtc_host.stop;
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    // main sequence
    initial
    begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        a = 7'($urandom(80) % 124);
        loc_writable = {$urandom, $urandom, $urandom, $urandom};
        loc_writable[a] = 1'b1;
        loc_writable[a + 7'h1] = 1'b1;
        loc_writable[a + 7'h2] = 1'b0;
        loc_writable[127] = 1'b1;
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        d4 = 8'($urandom);
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (2) @(negedge mclk);
        wr(a + 7'h1, d1, 1'b1);
        wr(a, d0, 1'b1);
        i_gtc_host.start;
        i_gtc_host.wbyte(8'hAB, ack);
        i_gtc_host.rbyte(1'b0, rd);
        i_gtc_host.stop;
        chk_byte(rd, d1);
        wr(a + 7'h2, d2, 1'b0);
        wr(7'h7F, d4, 1'b1);
        i_gtc_host.start;
        i_gtc_host.wbyte(8'h20, ack);
        chk_bit(ack, 1'b0);
        i_gtc_host.stop;
        open_cmd(8'h80, 1'b0);
        i_gtc_host.stop;
        open_cmd({1'b0, a + 7'h1}, 1'b1);
        exp_q.push_back({a + 7'h1, d2});
        i_gtc_host.wbyte(d2, ack);
        chk_bit(ack, 1'b1);
        i_gtc_host.wbyte(~d2, ack);
        chk_bit(ack, 1'b0);
        i_gtc_host.stop;
        open_cmd({1'b0, a}, 1'b1);
        i_gtc_host.start;
        i_gtc_host.wbyte(8'hAB, ack);
        i_gtc_host.rbyte(1'b1, rd);
        chk_byte(rd, d0);
        i_gtc_host.rbyte(1'b0, rd);
        chk_byte(rd, d2);
        i_gtc_host.stop;
        open_cmd(8'h7F, 1'b1);
        i_gtc_host.start;
        i_gtc_host.wbyte(8'hAB, ack);
        i_gtc_host.rbyte(1'b1, rd);
        chk_byte(rd, d4);
        i_gtc_host.rbyte(1'b0, rd);
        chk_byte(rd, 8'hFF);
        i_gtc_host.stop;
        for (i = 0; i < 2; i = i + 1)
        begin
            i_gtc_host.lowboth(40);
            i_gtc_host.stop;
        end
        chk_bit(sleep_mode, 1'b0);
        i_gtc_host.lowboth(40);
        for (i = 0; i < 100 && sleep_mode !== 1'b1; i = i + 1)
            @(negedge mclk);
        chk_bit(sleep_mode, 1'b1);
        chk_bit(sda_oe, 1'b0);
        chk_bit(exp_q.size() == 0, 1'b1);
        print_verdict;
    end
endmodule // gtc_target_tb
